// File: lbsf_pkg.sv
// Package: constants and types for the loop board status flag block
package lbsf_pkg;
    // ----------------------------------------
    // Status word bit positions
    // ----------------------------------------
    localparam int BIT_EXEC_ERR = 3;  // Execution error flag
    localparam int BIT_DB_ERR = 4;    // Config RAM corruption flag
    localparam int BIT_AUTO_COLD = 7; // Automatic cold start flag
    localparam int BIT_RUN = 11;      // Run status flag
    localparam int BIT_CHANGED = 15;  // Config changed while running flag
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_STATUS_WORD = 8'h00; // board_status_word, read only
    localparam logic [7:0] OFF_CONTROL = 8'h04;     // Start/stop/backup commands
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;    // Sticky events, write one to clear
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;    // Interrupt enables
    localparam logic [7:0] OFF_STATE = 8'h10;       // Live state, unrefreshed
    // ----------------------------------------
    // Control register fields (self clearing strobes)
    // ----------------------------------------
    localparam int CTL_HOT = 0;    // Request hot start
    localparam int CTL_COLD = 1;   // Request cold start
    localparam int CTL_STOP = 2;   // Stop the board
    localparam int CTL_BACKUP = 3; // Copy RAM data to flash
    // ----------------------------------------
    // Interrupt event bits
    // ----------------------------------------
    localparam int EV_REFRESH = 0;  // Status word refreshed
    localparam int EV_AUTO = 1;     // Automatic cold start done
    localparam int EV_CHANGED = 2;  // Download while running
    localparam int EV_BACKUP = 3;   // Backup to flash requested
    localparam int EV_W = 4;        // Event count
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint CLK_HZ = 125000000;        // System clock rate
    localparam longint REFRESH_MS = 1000;         // Refresh cycle, 1 sec
    localparam longint REFRESH_CYC = CLK_HZ * REFRESH_MS / 1000; // Cycles per refresh
    localparam logic [1:0] RESP_OKAY = 2'h0;      // AXI okay
    localparam logic [1:0] RESP_SLVERR = 2'h2;    // AXI slave error
    // ----------------------------------------
    // Board run state, Gray coded
    // ----------------------------------------
    typedef enum logic [1:0] {
        LBSF_STOPPED = 2'h0, // Board idle
        LBSF_RUNNING = 2'h1  // Board executing blocks
    } lbsf_run_type;
endpackage

// File: lbsf_tick.sv
// Divider that makes the one-second refresh enable pulse
`timescale 1ns/1ps
`default_nettype none
module lbsf_tick
    import lbsf_pkg::*;
#(
    parameter int unsigned PERIOD = 32'(REFRESH_CYC) // Cycles between pulses
) (
    input wire logic clk_sys, // System clock
    input wire logic rst,     // Async reset, high
    output logic tick         // One-cycle pulse each period
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] cnt; // Down counter
        logic tick;       // Registered pulse
    } lbsf_tick_st_type;
    lbsf_tick_st_type s_q, s_d;
    // Next state: reload on zero
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 32'h0) begin
            s_d.cnt = 32'(PERIOD - 1);
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt - 32'h1;
        end
    end
    // Registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule
`default_nettype wire

// File: lbsf_axil.sv
// AXI4-Lite slave front end giving single-cycle read/write strobes
`timescale 1ns/1ps
`default_nettype none
module lbsf_axil
    import lbsf_pkg::*;
(
    input wire logic clk_sys,             // System clock
    input wire logic rst,                 // Async reset, high
    input wire logic [7:0] s_axi_awaddr,  // Write address
    input wire logic s_axi_awvalid,       // Write address valid
    output logic s_axi_awready,           // Write address ready
    input wire logic [31:0] s_axi_wdata,  // Write data
    input wire logic [3:0] s_axi_wstrb,   // Byte enables
    input wire logic s_axi_wvalid,        // Write data valid
    output logic s_axi_wready,            // Write data ready
    output logic [1:0] s_axi_bresp,       // Write response
    output logic s_axi_bvalid,            // Write response valid
    input wire logic s_axi_bready,        // Write response ready
    input wire logic [7:0] s_axi_araddr,  // Read address
    input wire logic s_axi_arvalid,       // Read address valid
    output logic s_axi_arready,           // Read address ready
    output logic [31:0] s_axi_rdata,      // Read data
    output logic [1:0] s_axi_rresp,       // Read response
    output logic s_axi_rvalid,            // Read valid
    input wire logic s_axi_rready,        // Read ready
    output logic wr_en,                   // Write strobe
    output logic [7:0] wr_addr,           // Write address
    output logic [31:0] wr_data,          // Write data as received, not masked; strobes on wr_strb
    output logic [3:0] wr_strb,           // Write byte enables
    input wire logic wr_err,              // Write address unmapped
    output logic [7:0] rd_addr,           // Read address, combinational
    input wire logic [31:0] rd_data,      // Read data from bank
    input wire logic rd_err,              // Read address unmapped
    output logic rd_en                    // Read strobe
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic aw_got;       // Address held
        logic w_got;        // Data held
        logic [7:0] awaddr; // Held address
        logic [31:0] wdata; // Held data
        logic [3:0] wstrb;  // Held strobes
        logic bvalid;       // Response pending
        logic [1:0] bresp;  // Write response
        logic rvalid;       // Read data pending
        logic [31:0] rdata; // Read data
        logic [1:0] rresp;  // Read response
        logic awready;      // Write address ready, registered
        logic wready;       // Write data ready, registered
        logic arready;      // Read address ready, registered
    } lbsf_axil_st_type;
    lbsf_axil_st_type s_q, s_d;
    logic do_wr; // Both halves present
    logic do_rd; // Read accepted
    // Channel handshakes and responses
    always_comb begin
        s_d = s_q;
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        if (do_wr) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        do_rd = s_axi_arvalid && s_q.arready;
        if (do_rd) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_data;
            s_d.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        // Ready outputs come from flops; low for one cycle after reset
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
    end
    // Registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign wr_en = do_wr;
    assign wr_addr = s_q.awaddr;
    assign wr_data = s_q.wdata;
    assign wr_strb = s_q.wstrb;
    assign rd_addr = s_axi_araddr;
    assign rd_en = do_rd;
endmodule
`default_nettype wire

// File: lbsf_top.sv
// Loop board status word: flags, run control, refresh and interrupt
//
// Behaviour
// - Bit 3 is OR of block error codes
// - Bit 4 flags corrupted configuration RAM
// - Hot start with bad RAM becomes cold
// - Bit 7 marks substituted cold start, flash reload
// - Bit 7 is zero unless running
// - Bit 11 is one while running
// - Bit 15 set by download while running
// - Bit 15 cleared by any start
// - Downloads stay in RAM; backup is separate
// - All flags in one status word
// - Status word refreshed once per second
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module lbsf_top
    import lbsf_pkg::*;
#(
    parameter int NBLK = 8,                      // Function block count
    parameter int unsigned REFRESH = 32'(REFRESH_CYC) // Cycles per refresh
) (
    input wire logic clk_sys,                    // System clock 125 MHz
    input wire logic rst,                        // Async reset, high
    input wire logic [NBLK-1:0] blk_err_nz,      // Per block: block_error_code nonzero
    input wire logic ram_corrupt,                // RAM data check failed
    input wire logic download,                   // Pulse: block data downloaded to RAM
    input wire logic [7:0] s_axi_awaddr,         // Write address
    input wire logic s_axi_awvalid,              // Write address valid
    output logic s_axi_awready,                  // Write address ready
    input wire logic [31:0] s_axi_wdata,         // Write data
    input wire logic [3:0] s_axi_wstrb,          // Byte enables
    input wire logic s_axi_wvalid,               // Write data valid
    output logic s_axi_wready,                   // Write data ready
    output logic [1:0] s_axi_bresp,              // Write response
    output logic s_axi_bvalid,                   // Write response valid
    input wire logic s_axi_bready,               // Write response ready
    input wire logic [7:0] s_axi_araddr,         // Read address
    input wire logic s_axi_arvalid,              // Read address valid
    output logic s_axi_arready,                  // Read address ready
    output logic [31:0] s_axi_rdata,             // Read data
    output logic [1:0] s_axi_rresp,              // Read response
    output logic s_axi_rvalid,                   // Read valid
    input wire logic s_axi_rready,               // Read ready
    output logic flash_load,                     // Pulse: reload RAM from flash
    output logic flash_backup,                   // Pulse: write RAM to flash
    output logic irq                             // Level interrupt
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [NBLK+1:0] sy1_q, sy2_q; // Two-stage synchroniser
    logic dl_prev_q;               // Download edge history
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {download, ram_corrupt, blk_err_nz};
            sy2_q <= sy1_q;
        end
    end
    logic [NBLK-1:0] err_s; // Synced error indications
    logic corrupt_s;        // Synced RAM corruption
    logic dl_s;             // Synced download level
    assign err_s = sy2_q[NBLK-1:0];
    assign corrupt_s = sy2_q[NBLK];
    assign dl_s = sy2_q[NBLK+1];

    // ----------------------------------------
    // Refresh divider and bus slave
    // ----------------------------------------
    logic tick; // One-second enable
    lbsf_tick #(.PERIOD(REFRESH)) u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick)
    );
    logic wr_en, wr_err, rd_err;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    lbsf_axil u_axil (
        .clk_sys(clk_sys),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err),
        .rd_en()
    );

    // ----------------------------------------
    // Block state
    // ----------------------------------------
    typedef struct packed {
        lbsf_run_type run;   // Run state
        logic auto_cold;     // Last start was a substituted cold start
        logic changed;       // Download seen while running
        logic [15:0] word;   // Refreshed board_status_word
        logic [3:0] ev;      // Sticky interrupt status
        logic [3:0] mask;    // Interrupt mask
        logic load;          // Flash reload pulse
        logic backup;        // Flash backup pulse
        logic irq;           // Interrupt output
    } lbsf_st_type;
    lbsf_st_type s_q, s_d;
    logic [15:0] live;  // Unrefreshed flag word
    logic any_err;      // OR of block error codes
    logic hot_req, cold_req, stop_req, bk_req, dl_pulse, ctl_wr;
    logic [EV_W-1:0] ev_set; // Events this cycle

    // Reduce block error indications
    always_comb begin
        any_err = 1'b0;
        for (int i = 0; i < NBLK; i++) begin
            any_err = any_err | err_s[i];
        end
    end

    // Live flag word assembly
    always_comb begin
        live = 16'h0000;
        live[BIT_EXEC_ERR] = any_err;
        live[BIT_DB_ERR] = corrupt_s;
        live[BIT_AUTO_COLD] = s_q.auto_cold && (s_q.run == LBSF_RUNNING);
        live[BIT_RUN] = (s_q.run == LBSF_RUNNING);
        live[BIT_CHANGED] = s_q.changed;
    end

    // Control strobes decoded from bus writes
    assign ctl_wr = wr_en && (wr_addr == OFF_CONTROL) && wr_strb[0];
    assign hot_req = ctl_wr && wr_data[CTL_HOT];
    assign cold_req = ctl_wr && wr_data[CTL_COLD] && !wr_data[CTL_HOT];
    assign stop_req = ctl_wr && wr_data[CTL_STOP] && !wr_data[CTL_HOT] && !wr_data[CTL_COLD];
    assign bk_req = ctl_wr && wr_data[CTL_BACKUP];
    assign dl_pulse = dl_s && !dl_prev_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dl_prev_q <= 1'b0;
        end else begin
            dl_prev_q <= dl_s;
        end
    end

    // Unmapped address decode; status word write is accepted but ignored
    always_comb begin
        wr_err = !(wr_addr == OFF_STATUS_WORD || wr_addr == OFF_CONTROL ||
                   wr_addr == OFF_IRQ_STAT || wr_addr == OFF_IRQ_MASK ||
                   wr_addr == OFF_STATE);
        rd_err = !(rd_addr == OFF_STATUS_WORD || rd_addr == OFF_CONTROL ||
                   rd_addr == OFF_IRQ_STAT || rd_addr == OFF_IRQ_MASK ||
                   rd_addr == OFF_STATE);
        case (rd_addr)
            OFF_STATUS_WORD: rd_data = {16'h0000, s_q.word};
            OFF_IRQ_STAT: rd_data = {28'h0000000, s_q.ev};
            OFF_IRQ_MASK: rd_data = {28'h0000000, s_q.mask};
            OFF_STATE: rd_data = {16'h0000, live};
            default: rd_data = 32'h00000000;
        endcase
    end

    // Main next-state logic
    always_comb begin
        s_d = s_q;
        s_d.load = 1'b0;
        s_d.backup = 1'b0;
        ev_set = '0;
        // Start requests
        if (hot_req || cold_req) begin
            s_d.run = LBSF_RUNNING;
            s_d.changed = 1'b0;
            s_d.auto_cold = hot_req && corrupt_s;
            s_d.load = cold_req || corrupt_s;
            ev_set[EV_AUTO] = hot_req && corrupt_s;
        end else if (stop_req) begin
            s_d.run = LBSF_STOPPED;
            s_d.auto_cold = 1'b0;
        end else if (dl_pulse && s_q.run == LBSF_RUNNING) begin
            s_d.changed = 1'b1;
            ev_set[EV_CHANGED] = 1'b1;
        end
        // Flash written only on explicit backup
        if (bk_req) begin
            s_d.backup = 1'b1;
            ev_set[EV_BACKUP] = 1'b1;
        end
        // One-second refresh of the host-visible word
        if (tick) begin
            s_d.word = live;
            ev_set[EV_REFRESH] = 1'b1;
        end
        // Mask write
        if (wr_en && wr_addr == OFF_IRQ_MASK && wr_strb[0]) begin
            s_d.mask = wr_data[EV_W-1:0];
        end
        // Write one to clear, new events win
        if (wr_en && wr_addr == OFF_IRQ_STAT && wr_strb[0]) begin
            s_d.ev = s_q.ev & ~wr_data[EV_W-1:0];
        end
        s_d.ev = s_d.ev | ev_set;
        s_d.irq = |(s_d.ev & s_d.mask);
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign flash_load = s_q.load;
    assign flash_backup = s_q.backup;
    assign irq = s_q.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    localparam logic [15:0] FLAG_BITS = (16'h1 << BIT_EXEC_ERR) | (16'h1 << BIT_DB_ERR) |
        (16'h1 << BIT_AUTO_COLD) | (16'h1 << BIT_RUN) | (16'h1 << BIT_CHANGED); // Flag bits
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    exec_err_flag_a: assert property (tick |=> s_q.word[BIT_EXEC_ERR] == $past(any_err))
        else $error("exec error flag not OR of codes");
    db_err_flag_a: assert property (tick |=> s_q.word[BIT_DB_ERR] == $past(corrupt_s))
        else $error("db error flag wrong");
    hot_bad_ram_a: assert property (hot_req && corrupt_s |=> flash_load && s_q.auto_cold)
        else $error("hot start on bad RAM not cold");
    auto_cold_set_a: assert property (hot_req && !corrupt_s |=> !s_q.auto_cold)
        else $error("auto cold set without cause");
    auto_cold_stop_a: assert property (!s_q.word[BIT_RUN] |-> !s_q.word[BIT_AUTO_COLD])
        else $error("auto cold set while stopped");
    run_flag_a: assert property (tick |=> s_q.word[BIT_RUN] == ($past(s_q.run) == LBSF_RUNNING))
        else $error("run flag wrong");
    changed_set_a: assert property (dl_pulse && s_q.run == LBSF_RUNNING && !ctl_wr |=> s_q.changed)
        else $error("changed flag not set");
    changed_clr_a: assert property (hot_req || cold_req |=> !s_q.changed)
        else $error("changed flag not cleared by start");
    backup_only_a: assert property (flash_backup |-> $past(bk_req))
        else $error("backup without request");
    word_hold_a: assert property (!tick |=> $stable(s_q.word))
        else $error("status word changed off refresh");
    irq_level_a: assert property (irq == |(s_q.ev & s_q.mask))
        else $error("irq not masked status");
    word_layout_a: assert property ((s_q.word & ~FLAG_BITS) == 16'h0000)
        else $error("status word has stray bits");
    cov_hot_c: cover property (hot_req && !corrupt_s);
    cov_auto_c: cover property (hot_req && corrupt_s);
    cov_change_c: cover property (dl_pulse && s_q.run == LBSF_RUNNING);
    cov_refresh_c: cover property (tick && s_q.run == LBSF_RUNNING);
endmodule
`default_nettype wire

// File: lbsf_host.sv
// Host controller model: AXI4-Lite master that reads and writes the board registers
`timescale 1ns/1ps
`default_nettype none
module lbsf_host
    import lbsf_pkg::*;
(
    input wire logic clk_sys,             // System clock
    output logic [7:0] s_axi_awaddr,      // Write address
    output logic s_axi_awvalid,           // Write address valid
    input wire logic s_axi_awready,       // Write address ready
    output logic [31:0] s_axi_wdata,      // Write data
    output logic [3:0] s_axi_wstrb,       // Byte enables
    output logic s_axi_wvalid,            // Write data valid
    input wire logic s_axi_wready,        // Write data ready
    input wire logic [1:0] s_axi_bresp,   // Write response
    input wire logic s_axi_bvalid,        // Write response valid
    output logic s_axi_bready,            // Write response ready
    output logic [7:0] s_axi_araddr,      // Read address
    output logic s_axi_arvalid,           // Read address valid
    input wire logic s_axi_arready,       // Read address ready
    input wire logic [31:0] s_axi_rdata,  // Read data
    input wire logic [1:0] s_axi_rresp,   // Read response
    input wire logic s_axi_rvalid,        // Read valid
    output logic s_axi_rready             // Read ready
);
    // ----------------------------------------
    // Idle bus at time zero
    // ----------------------------------------
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // Write one word; status word writes only in the scenario that tests them
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!done) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // Read one word, held until the answer arrives
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!done) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: loop_board_status_flags_test.sv
// Self-checking bench for the loop board status word block
`timescale 1ns/1ps
`default_nettype none
module loop_board_status_flags_test
    import lbsf_pkg::*;
;
    localparam logic [31:0] FE = 32'h1 << BIT_EXEC_ERR;  // Execution error
    localparam logic [31:0] FD = 32'h1 << BIT_DB_ERR;    // RAM error
    localparam logic [31:0] FA = 32'h1 << BIT_AUTO_COLD; // Auto cold start
    localparam logic [31:0] FR = 32'h1 << BIT_RUN;       // Running
    localparam logic [31:0] FC = 32'h1 << BIT_CHANGED;   // Changed
    logic clk_sys, rst, ram_corrupt, download, flash_load, flash_backup, irq;
    logic [7:0] blk_err_nz, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_mismatch = 0;
    int compares = 0;
    int n_load = 0;
    int n_backup = 0;
    // ----------------------------------------
    // Design, host model and clock
    // ----------------------------------------
    lbsf_top #(.NBLK(8), .REFRESH(20)) i_dut (.clk_sys, .rst, .blk_err_nz, .ram_corrupt,
        .download, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .flash_load, .flash_backup, .irq);
    lbsf_host i_host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Count flash pulses
    always @(posedge clk_sys) begin
        if (flash_load === 1'b1) n_load++;
        if (flash_backup === 1'b1) n_backup++;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_host.rd(a, d, r);
        chk(d, exp);
        chk(32'(r), 32'(RESP_OKAY));
    endtask
    task automatic settle();
        repeat (30) @(posedge clk_sys);
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (6000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {blk_err_nz, ram_corrupt, download} = '0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(OFF_STATUS_WORD, 32'h0);
        i_host.rd(8'h14, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        i_host.wr(8'h14, 32'h1, r);
        chk(32'(r), 32'(RESP_SLVERR));
        blk_err_nz <= 8'h80;
        ram_corrupt <= 1'b1;
        settle();
        rd_chk(OFF_STATUS_WORD, FE | FD);
        i_host.wr(OFF_IRQ_MASK, 32'h6, r);
        i_host.wr(OFF_CONTROL, 32'h1, r);
        settle();
        rd_chk(OFF_STATUS_WORD, FE | FD | FA | FR);
        chk(32'(n_load), 32'h1);
        chk(32'(irq), 32'h1);
        rd_chk(OFF_STATE, FE | FD | FA | FR);
        rd_chk(OFF_IRQ_MASK, 32'h6);
        rd_chk(OFF_IRQ_STAT, 32'h3);
        rd_chk(OFF_CONTROL, 32'h0);
        i_host.wr(OFF_IRQ_STAT, 32'hF, r);
        @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        blk_err_nz <= 8'h0;
        ram_corrupt <= 1'b0;
        download <= 1'b1;
        repeat (3) @(posedge clk_sys);
        download <= 1'b0;
        settle();
        rd_chk(OFF_STATUS_WORD, FA | FR | FC);
        chk(32'(irq), 32'h1);
        chk(32'(n_backup), 32'h0);
        i_host.wr(OFF_STATUS_WORD, 32'hFFFF, r);
        chk(32'(r), 32'(RESP_OKAY));
        settle();
        rd_chk(OFF_STATUS_WORD, FA | FR | FC);
        i_host.wr(OFF_CONTROL, 32'h4, r);
        settle();
        rd_chk(OFF_STATUS_WORD, FC);
        i_host.wr(OFF_CONTROL, 32'h2, r);
        settle();
        rd_chk(OFF_STATUS_WORD, FR);
        chk(32'(n_load), 32'h2);
        i_host.wr(OFF_CONTROL, 32'h8, r);
        repeat (2) @(posedge clk_sys);
        chk(32'(n_backup), 32'h1);
        download <= 1'b1;
        repeat (3) @(posedge clk_sys);
        download <= 1'b0;
        i_host.wr(OFF_CONTROL, 32'h1, r);
        settle();
        rd_chk(OFF_STATUS_WORD, FR);
        chk(32'(n_load), 32'h2);
        test_done();
    end
endmodule
`default_nettype wire
